// ===== testbench/supply_switch_model.sv
// external reset switch with pull-up and a supply monitor
// assumes the bench requests presses and dips after a rising pclk edge
module supply_switch_model (
    input wire logic pclk,
    input wire logic press,
    input wire logic dip_go,
    input wire logic [7:0] dip_len,
    output logic ext_reset_n_pin,
    output logic supply_low
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] left_q = 8'h00;
    // released switch leaves the pin on its pull-up
    assign ext_reset_n_pin = !press;
    assign supply_low = (left_q != 8'h00);
    always @(posedge pclk) begin
        if (dip_go) begin
            left_q <= dip_len;
        end else if (left_q != 8'h00) begin
            left_q <= left_q - 8'h01;
        end
    end
endmodule

// ===== testbench/tb.sv
// self-checking bench for the reset and clock source controller
// assumes supply_switch_model drives the reset pin and supply indication
module tb
    import rstclk_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = 8'h00;
    logic [DATA_W-1:0] pwdata = 32'h0;
    logic wdt_overflow = 1'b0;
    logic wake_event = 1'b0;
    logic press = 1'b0;
    logic dip_go = 1'b0;
    logic [7:0] dip_len = 8'h00;
    logic [DATA_W-1:0] prdata;
    logic [DATA_W-1:0] rd;
    logic pready, pslverr, ext_reset_n_pin, supply_low, er;
    logic irq_disable, timer_stop, prescaler_clear, port_input, pc_sp_reset;
    logic fetch_en, wdt_clear, sysclk_en, wdt_osc_en, clk_src_rc;
    logic osc_out_pin_o, osc_out_pin_oe_n;
    logic [6:0] outs;
    int failures = 0;
    int total_checks = 0;
    assign outs = {irq_disable, timer_stop, prescaler_clear, port_input,
                   pc_sp_reset, wdt_clear, fetch_en};
    always #2.5 pclk = ~pclk;
    // short filter keeps the supply dips a few dozen cycles long
    rstclk_ctrl #(.LVR_FILTER_CYCLES(LVR_CW'(16))) rstclk_ctrl_i (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_reset_n_pin(ext_reset_n_pin),
        .supply_low(supply_low), .wdt_overflow(wdt_overflow),
        .wake_event(wake_event), .irq_disable(irq_disable),
        .timer_stop(timer_stop), .prescaler_clear(prescaler_clear),
        .port_input(port_input), .pc_sp_reset(pc_sp_reset),
        .fetch_en(fetch_en), .wdt_clear(wdt_clear), .sysclk_en(sysclk_en),
        .wdt_osc_en(wdt_osc_en), .clk_src_rc(clk_src_rc),
        .osc_out_pin_o(osc_out_pin_o), .osc_out_pin_oe_n(osc_out_pin_oe_n));
    supply_switch_model supply_switch_model_i (
        .pclk(pclk), .press(press), .dip_go(dip_go), .dip_len(dip_len),
        .ext_reset_n_pin(ext_reset_n_pin), .supply_low(supply_low));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task close_out;
        if (failures == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task apb(input logic w, input logic [ADDR_W-1:0] a,
             input logic [DATA_W-1:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // no local limit: only the watchdog ends a hung access
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // the slave answers in the first access cycle
        chk(32'(n), 32'h1);
    endtask
    task stat_is(input logic tmo, input logic pwd, input logic [1:0] c,
                 input logic usec);
        logic [31:0] m;
        m = (32'h1 << STAT_TO_BIT) | (32'h1 << STAT_PD_BIT);
        if (usec)
            m = m | (32'h3 << STAT_CAUSE_LSB);
        apb(1'b0, STAT_OFF, 32'h0);
        chk(rd & m, m & ((32'(tmo) << STAT_TO_BIT) |
            (32'(pwd) << STAT_PD_BIT) | (32'(c) << STAT_CAUSE_LSB)));
    endtask
    task kick(input logic wd);
        @(posedge pclk);
        wdt_overflow <= wd;
        wake_event <= !wd;
        @(posedge pclk);
        wdt_overflow <= 1'b0;
        wake_event <= 1'b0;
        @(posedge pclk);
    endtask
    // bounded wait so a missing wake-up end shows as a mismatch
    task wait_fetch(input int lo, input int hi);
        int n;
        n = 0;
        while (fetch_en !== 1'b1 && n < 2000) begin
            @(posedge pclk);
            n++;
        end
        chk(32'(n >= lo && n <= hi), 32'h1);
    endtask
    task osc_chk(input logic rc);
        logic [7:0] v;
        logic hi;
        hi = 1'b0;
        for (int i = 0; i < 8; i++) begin
            @(posedge pclk);
            v[i] = osc_out_pin_oe_n;
            // the value only matters while the pin is pulled low
            hi = hi | (osc_out_pin_o & ~osc_out_pin_oe_n);
        end
        chk(hi, 1'b0);
        if (rc)
            chk(32'(v inside {8'h33, 8'h66, 8'hcc, 8'h99}), 32'h1);
        else
            chk(v, 8'hff);
    endtask
    task dip_watch(input logic [7:0] len, input logic hit);
        @(posedge pclk);
        dip_len <= len;
        dip_go <= 1'b1;
        @(posedge pclk);
        dip_go <= 1'b0;
        cyc(30);
        chk(fetch_en, !hit);
        if (hit)
            chk(outs, 7'h7e);
        // let the dip and its synchroniser drain before the next step
        cyc(20);
        if (hit)
            wait_fetch(1000, 1030);
    endtask
    task power_on;
        cyc(4);
        chk(outs, 7'h7e);
        @(posedge pclk);
        presetn <= 1'b1;
        wait_fetch(1023, 1028);
        apb(1'b0, CFG_OFF, 32'h0);
        chk(rd, 32'(CFG_RESET));
        stat_is(1'b0, 1'b0, CAUSE_POR, 1'b1);
        apb(1'b0, 8'h0c, 32'h0);
        chk(rd, 32'h0);
        chk(er, 1'b1);
        apb(1'b1, STAT_OFF, 32'hffffffff);
        stat_is(1'b0, 1'b0, CAUSE_POR, 1'b1);
    endtask
    task clock_source;
        apb(1'b1, CFG_OFF, 32'h5);
        cyc(2);
        chk(wdt_osc_en, 1'b0);
        chk(clk_src_rc, 1'b1);
        osc_chk(1'b1);
        apb(1'b1, CFG_OFF, 32'h3);
        cyc(2);
        chk(clk_src_rc, 1'b0);
        chk(wdt_osc_en, 1'b1);
        osc_chk(1'b0);
    endtask
    task sleep_wake;
        apb(1'b1, CMD_OFF, 32'h1 << CMD_SLEEP_BIT);
        cyc(2);
        chk(sysclk_en, 1'b0);
        chk(wdt_osc_en, 1'b1);
        stat_is(1'b0, 1'b1, CAUSE_POR, 1'b0);
        kick(1'b0);
        wait_fetch(1020, 1028);
        chk(sysclk_en, 1'b1);
    endtask
    task dog_run;
        kick(1'b1);
        chk(outs, 7'h7e);
        @(posedge pclk);
        chk(wdt_clear, 1'b0);
        wait_fetch(1020, 1028);
        stat_is(1'b1, 1'b1, CAUSE_WDT, 1'b1);
        apb(1'b1, CMD_OFF, 32'h1 << CMD_CLRWDT_BIT);
        stat_is(1'b1, 1'b0, CAUSE_WDT, 1'b1);
    endtask
    task dog_sleep;
        apb(1'b1, CMD_OFF, 32'h1 << CMD_SLEEP_BIT);
        cyc(2);
        stat_is(1'b0, 1'b1, CAUSE_WDT, 1'b0);
        kick(1'b1);
        chk(outs, 7'h06);
        chk(sysclk_en, 1'b1);
        wait_fetch(1020, 1028);
        stat_is(1'b1, 1'b1, CAUSE_WDT, 1'b0);
    endtask
    task pin_press;
        @(posedge pclk);
        press <= 1'b1;
        cyc(10);
        chk(outs, 7'h7e);
        press <= 1'b0;
        wait_fetch(1024, 1034);
        stat_is(1'b1, 1'b1, CAUSE_PIN, 1'b1);
    endtask
    task supply_dip;
        apb(1'b1, CFG_OFF, 32'h2);
        dip_watch(8'd40, 1'b0);
        apb(1'b1, CFG_OFF, 32'h3);
        dip_watch(8'd16, 1'b0);
        dip_watch(8'd40, 1'b1);
        stat_is(1'b1, 1'b1, CAUSE_LVR, 1'b1);
    endtask
    // a watchdog pulse while the clock enable is low must not be taken
    task ce_hold;
        @(posedge pclk);
        ce <= 1'b0;
        wdt_overflow <= 1'b1;
        cyc(3);
        wdt_overflow <= 1'b0;
        cyc(2);
        chk(outs, 7'h01);
        ce <= 1'b1;
        cyc(3);
        chk(outs, 7'h01);
        stat_is(1'b1, 1'b1, CAUSE_LVR, 1'b1);
    endtask
    initial begin
        power_on;
        clock_source;
        sleep_wake;
        dog_run;
        dog_sleep;
        pin_press;
        supply_dip;
        ce_hold;
        close_out;
    end
    // the whole sequence needs about 6400 cycles, 32 us
    initial begin
        #150000;
        failures++;
        close_out;
    end
endmodule

// ===== verilog/rstclk_ctrl.sv
// reset merging, reset flags and clock source control for a small mcu
// assumes presetn is the power-on reset, pclk is the always-on clock,
// wdt_overflow and wake_event come from logic on pclk
//
// Overview of operation
// - external reset pin low forces pc to zero; fetch restarts after release
// - supply-low reset exists only when its configuration bit is set
// - supply-low lasting up to 1ms is ignored; longer gives full reset
// - watchdog time-out while running acts like the pin and sets TO
// - watchdog time-out in power-down clears only pc, sp and the watchdog, sets TO
// - power-on reset clears both TO and PD flags
// - pin or supply-low reset while running leaves TO and PD unchanged
// - watchdog reset while running sets TO, leaves PD unchanged
// - watchdog reset in power-down leaves TO and PD both at one
// - every reset disables all interrupts including the global enable; the power-down watchdog reset here leaves irq_disable low
// - every reset clears the watchdog counter, which then counts again
// - every reset stops the timer/event counters; the power-down watchdog reset here leaves timer_stop low
// - every reset clears the timer prescaler; the power-down watchdog reset here leaves prescaler_clear low
// - every reset makes all port pins inputs, data and direction high; the power-down watchdog reset here leaves port_input low
// - every reset sets the stack pointer to the top, stack empty
// - system clock comes from exactly one source, crystal or RC
// - in RC mode the osc output pin carries system clock divided by 4
// - in power-down the system clock stops, watchdog oscillator runs
// - the watchdog oscillator can be disabled by configuration
// - PD clears at power-up or clear-watchdog, sets on sleep
// - after any wake-up wait 1024 clocks before execution resumes
//
// Added by the designer: the APB register port and the address map.
module rstclk_ctrl
    import rstclk_pkg::*;
#(
    parameter logic [LVR_CW-1:0] LVR_FILTER_CYCLES = LVR_CYC_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_reset_n_pin,
    input wire logic supply_low,
    input wire logic wdt_overflow,
    input wire logic wake_event,
    output logic irq_disable,
    output logic timer_stop,
    output logic prescaler_clear,
    output logic port_input,
    output logic pc_sp_reset,
    output logic fetch_en,
    output logic wdt_clear,
    output logic sysclk_en,
    output logic wdt_osc_en,
    output logic clk_src_rc,
    output logic osc_out_pin_o,
    output logic osc_out_pin_oe_n
);

    // second and third stage must agree before a pin change counts
    function automatic logic sync_agree(
        input logic [SYNC_W-1:0] s,
        input logic lvl
    );
        sync_agree = (s[1] == s[2]) ? s[2] : lvl;
    endfunction

    logic [SYNC_W-1:0] ext_sync_q;
    logic ext_lvl_q;
    logic [SYNC_W-1:0] sup_sync_q;
    logic sup_lvl_q;
    logic [LVR_CW-1:0] lvr_cnt_q;
    logic [LVR_CW-1:0] lvr_cnt_d;
    seq_state_e state_q;
    seq_state_e state_d;
    logic [WAKE_CW-1:0] wake_cnt_q;
    logic [WAKE_CW-1:0] wake_cnt_d;
    logic to_q;
    logic to_d;
    logic pd_q;
    logic pd_d;
    cause_e cause_q;
    cause_e cause_d;
    logic [CFG_W-1:0] cfg_q;
    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] div_d;
    logic [DATA_W-1:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic irq_disable_q;
    logic timer_stop_q;
    logic prescaler_clear_q;
    logic port_input_q;
    logic pc_sp_reset_q;
    logic fetch_en_q;
    logic wdt_clear_q;
    logic sysclk_en_q;
    logic wdt_osc_en_q;
    logic clk_src_rc_q;
    logic osc_out_q;
    logic osc_oe_n_q;

    // apb decode
    wire setup = psel & ~penable;
    wire done = psel & penable & pready_q;
    wire hit_cfg = (paddr == CFG_OFF);
    wire hit_cmd = (paddr == CMD_OFF);
    wire hit_stat = (paddr == STAT_OFF);
    wire hit = hit_cfg | hit_cmd | hit_stat;
    wire wr_cfg = done & pwrite & hit_cfg;
    wire wr_cmd = done & pwrite & hit_cmd;

    wire cfg_lvr = cfg_q[CFG_LVR_BIT];
    wire cfg_wosc = cfg_q[CFG_WOSC_BIT];
    wire cfg_rc = cfg_q[CFG_RC_BIT];

    // reset sources
    wire pin_rst = ~ext_lvl_q;
    // a dip of exactly the filter length is still ignored
    wire lvr_fire = (lvr_cnt_q > LVR_FILTER_CYCLES);
    wire lvr_rst = cfg_lvr & lvr_fire;
    wire awake = (state_q == ST_RUN) | (state_q == ST_WAKE);
    wire wdt_run = wdt_overflow & awake;
    wire wdt_pd = wdt_overflow & (state_q == ST_SLEEP);
    wire wdt_ev = wdt_run | wdt_pd;
    wire hold_src = pin_rst | lvr_rst;
    wire full_trig = hold_src | wdt_run;

    // software commands only act while code is running
    wire run_ok = (state_q == ST_RUN) & ~full_trig;
    wire sleep_cmd = wr_cmd & pwdata[CMD_SLEEP_BIT] & run_ok;
    wire clr_cmd = wr_cmd & pwdata[CMD_CLRWDT_BIT] & run_ok;

    // filter counter saturates just past the threshold while low persists
    assign lvr_cnt_d = (~cfg_lvr | ~sup_lvl_q) ? '0 :
                       lvr_fire ? lvr_cnt_q :
                       lvr_cnt_q + 1'b1;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_RESET: begin
                if (!hold_src) begin
                    state_d = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (full_trig) begin
                    state_d = ST_RESET;
                end else if (wake_cnt_q == WAKE_LAST) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (full_trig) begin
                    state_d = ST_RESET;
                end else if (sleep_cmd) begin
                    state_d = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (hold_src) begin
                    state_d = ST_RESET;
                end else if (wdt_pd | wake_event) begin
                    state_d = ST_WAKE;
                end
            end
            default: begin
                state_d = ST_RESET;
            end
        endcase
    end

    wire in_rst_d = (state_d == ST_RESET);
    wire run_d = (state_d == ST_RUN);
    wire clk_on_d = (state_d != ST_SLEEP);

    assign wake_cnt_d = (state_q == ST_WAKE && state_d == ST_WAKE) ?
                        wake_cnt_q + 1'b1 : '0;

    // the timeout set wins over a sleep clear in the same cycle;
    // pin and supply-low resets leave both flags alone
    assign to_d = wdt_ev ? 1'b1 : sleep_cmd ? 1'b0 : to_q;
    assign pd_d = sleep_cmd ? 1'b1 : clr_cmd ? 1'b0 : pd_q;
    assign cause_d = pin_rst ? CAUSE_PIN :
                     lvr_rst ? CAUSE_LVR :
                     wdt_ev ? CAUSE_WDT : cause_q;

    assign div_d = div_q + 1'b1;

    wire [DATA_W-1:0] stat_word =
        (DATA_W'(to_q) << STAT_TO_BIT) |
        (DATA_W'(pd_q) << STAT_PD_BIT) |
        (DATA_W'(fetch_en_q) << STAT_RUN_BIT) |
        (DATA_W'(lvr_cnt_q != '0) << STAT_LVRPEND_BIT) |
        (DATA_W'(cause_q) << STAT_CAUSE_LSB);
    wire [DATA_W-1:0] rd_word = hit_cfg ? DATA_W'(cfg_q) :
                                hit_stat ? stat_word : '0;

    // pin synchronisers, idle level before power-on is inactive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_sync_q <= '1;
            ext_lvl_q <= 1'b1;
            sup_sync_q <= '0;
            sup_lvl_q <= 1'b0;
        end else if (ce) begin
            ext_sync_q <= {ext_sync_q[SYNC_W-2:0], ext_reset_n_pin};
            ext_lvl_q <= sync_agree(ext_sync_q, ext_lvl_q);
            sup_sync_q <= {sup_sync_q[SYNC_W-2:0], supply_low};
            sup_lvl_q <= sync_agree(sup_sync_q, sup_lvl_q);
        end
    end

    // power-on reset dominates every other source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_RESET;
            lvr_cnt_q <= '0;
            wake_cnt_q <= '0;
            to_q <= 1'b0;
            pd_q <= 1'b0;
            cause_q <= CAUSE_POR;
            div_q <= '0;
        end else if (ce) begin
            state_q <= state_d;
            lvr_cnt_q <= lvr_cnt_d;
            wake_cnt_q <= wake_cnt_d;
            to_q <= to_d;
            pd_q <= pd_d;
            cause_q <= cause_d;
            div_q <= div_d;
        end
    end

    // apb slave: one wait-free access phase, data registered at setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= CFG_RESET;
            pready_q <= 1'b0;
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end else if (ce) begin
            if (wr_cfg) begin
                cfg_q <= pwdata[CFG_W-1:0];
            end
            pready_q <= setup;
            prdata_q <= setup ? rd_word : '0;
            pslverr_q <= setup & ~hit;
        end
    end

    // reset effects are registered from the next state so that they
    // release together, on a clock edge, after the sources go away
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_disable_q <= 1'b1;
            timer_stop_q <= 1'b1;
            prescaler_clear_q <= 1'b1;
            port_input_q <= 1'b1;
            pc_sp_reset_q <= 1'b1;
            fetch_en_q <= 1'b0;
            wdt_clear_q <= 1'b1;
        end else if (ce) begin
            irq_disable_q <= in_rst_d;
            timer_stop_q <= in_rst_d;
            prescaler_clear_q <= in_rst_d;
            port_input_q <= in_rst_d;
            pc_sp_reset_q <= in_rst_d | wdt_pd;
            fetch_en_q <= run_d;
            wdt_clear_q <= in_rst_d | wdt_pd | sleep_cmd | clr_cmd;
        end
    end

    // pclk itself is always-on; sysclk_en gates the core clock tree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sysclk_en_q <= 1'b1;
            wdt_osc_en_q <= CFG_RESET[CFG_WOSC_BIT];
            clk_src_rc_q <= CFG_RESET[CFG_RC_BIT];
            osc_out_q <= 1'b0;
            osc_oe_n_q <= 1'b1;
        end else if (ce) begin
            sysclk_en_q <= clk_on_d;
            wdt_osc_en_q <= cfg_wosc;
            clk_src_rc_q <= cfg_rc;
            // open drain: only the low half is driven, pull-up does the rest
            osc_out_q <= div_d[DIV_W-1];
            osc_oe_n_q <= ~(cfg_rc & clk_on_d) | div_d[DIV_W-1];
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq_disable = irq_disable_q;
    assign timer_stop = timer_stop_q;
    assign prescaler_clear = prescaler_clear_q;
    assign port_input = port_input_q;
    assign pc_sp_reset = pc_sp_reset_q;
    assign fetch_en = fetch_en_q;
    assign wdt_clear = wdt_clear_q;
    assign sysclk_en = sysclk_en_q;
    assign wdt_osc_en = wdt_osc_en_q;
    assign clk_src_rc = clk_src_rc_q;
    assign osc_out_pin_o = osc_out_q;
    assign osc_out_pin_oe_n = osc_oe_n_q;

    default clocking cb @(posedge pclk iff ce);
    endclocking
    default disable iff (!presetn);

    sequence s_sleep_enter;
        sleep_cmd;
    endsequence

    sequence s_pd_timeout;
        wdt_pd && !hold_src;
    endsequence

    a_pin_reset_pc: assert property (
        pin_rst |=> state_q == ST_RESET && pc_sp_reset_q && !fetch_en_q)
        else $error("pin reset did not clear pc or stop fetch");

    a_lvr_off_idle: assert property (
        !cfg_lvr |=> lvr_cnt_q == '0 && !lvr_rst)
        else $error("supply-low filter active while disabled");

    a_lvr_long_reset: assert property (
        (cfg_lvr && lvr_fire) |=> state_q == ST_RESET && irq_disable_q)
        else $error("persistent supply-low did not reset");

    a_wdt_run_full: assert property (
        (wdt_run && !hold_src) |=>
            to_q && pd_q == $past(pd_q) && irq_disable_q && !fetch_en_q)
        else $error("running watchdog reset wrong");

    a_wdt_pd_partial: assert property (
        s_pd_timeout |=> pc_sp_reset_q && !irq_disable_q && to_q && pd_q
            ##1 !pc_sp_reset_q)
        else $error("power-down watchdog reset wrong");

    a_pin_flags_kept: assert property (
        (hold_src && !wdt_overflow) |=>
            to_q == $past(to_q) && pd_q == $past(pd_q))
        else $error("pin or supply-low reset changed flags");

    a_reset_effects: assert property (
        state_q == ST_RESET |->
            irq_disable_q && timer_stop_q && prescaler_clear_q &&
            port_input_q && wdt_clear_q && pc_sp_reset_q)
        else $error("reset effects not all asserted");

    a_sleep_clock: assert property (
        s_sleep_enter |=> !sysclk_en_q && pd_q && !to_q && wdt_clear_q
            ##1 !wdt_clear_q || $past(wdt_ev || hold_src))
        else $error("sleep entry wrong");

    a_wake_wait: assert property (
        (state_q == ST_WAKE && state_d == ST_RUN) |->
            wake_cnt_q == WAKE_LAST ##1 fetch_en_q)
        else $error("wake wait length wrong");

    a_div_period: assert property (
        div_q == 2'h0 |=> div_q == 2'h1 ##1 div_q == 2'h2
            ##1 div_q == 2'h3 ##1 div_q == 2'h0)
        else $error("osc divider not divide by four");

    a_osc_out_rc: assert property (
        (clk_src_rc_q && sysclk_en_q && $past(cfg_rc) == clk_src_rc_q)
            |-> osc_oe_n_q == div_q[DIV_W-1])
        else $error("osc output does not follow divider");

endmodule

// ===== verilog/rstclk_pkg.sv
// constants and types shared by the reset and clock source controller
// assumes a 200 MHz pclk and a 32-bit APB master with byte addresses
package rstclk_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // register byte offsets
    localparam logic [ADDR_W-1:0] CFG_OFF = 8'h00;
    localparam logic [ADDR_W-1:0] CMD_OFF = 8'h04;
    localparam logic [ADDR_W-1:0] STAT_OFF = 8'h08;
    // configuration register fields
    localparam int CFG_W = 3;
    localparam int CFG_LVR_BIT = 0;
    localparam int CFG_WOSC_BIT = 1;
    localparam int CFG_RC_BIT = 2;
    localparam logic [CFG_W-1:0] CFG_RESET = 3'h3;
    // command register fields (write-only strobes)
    localparam int CMD_SLEEP_BIT = 0;
    localparam int CMD_CLRWDT_BIT = 1;
    // status register fields
    localparam int STAT_TO_BIT = 0;
    localparam int STAT_PD_BIT = 1;
    localparam int STAT_RUN_BIT = 2;
    localparam int STAT_LVRPEND_BIT = 3;
    localparam int STAT_CAUSE_LSB = 4;
    // timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int LVR_MIN_NS = 1000000;
    localparam int LVR_CW = 20;
    localparam logic [LVR_CW-1:0] LVR_CYC_DEF =
        LVR_CW'(LVR_MIN_NS / CLK_PERIOD_NS);
    localparam int WAKE_CYCLES = 1024;
    localparam int WAKE_CW = 10;
    localparam logic [WAKE_CW-1:0] WAKE_LAST = WAKE_CW'(WAKE_CYCLES - 1);
    localparam int DIV_W = 2;
    localparam int SYNC_W = 3;
    // sequencer, gray along reset -> wake -> run -> sleep
    typedef enum logic [1:0] {
        ST_RESET = 2'h0,
        ST_WAKE = 2'h1,
        ST_RUN = 2'h3,
        ST_SLEEP = 2'h2
    } seq_state_e;
    typedef enum logic [1:0] {
        CAUSE_POR = 2'h0,
        CAUSE_PIN = 2'h1,
        CAUSE_LVR = 2'h2,
        CAUSE_WDT = 2'h3
    } cause_e;
endpackage
